// File: verilog/smtc_consts.vh
/*
 Constants for the static memory timing block: register offsets,
 field positions, reset values and writable-bit masks.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SMTC_CONSTS_VH
`define SMTC_CONSTS_VH
// Register word offsets inside one chip-select group
`define SMTC_GROUP_STRIDE   8'h10
`define SMTC_OFS_SETUP      2'h0
`define SMTC_OFS_PULSE      2'h1
`define SMTC_OFS_CYCLE      2'h2
`define SMTC_OFS_MODE       2'h3
`define SMTC_STATUS_ADDR    8'h80
// Reset values
`define SMTC_RST_SETUP      32'h00000000
`define SMTC_RST_PULSE      32'h01010101
`define SMTC_RST_CYCLE      32'h00010001
`define SMTC_RST_MODE       32'h10001000
// Writable bits, all others read as zero
`define SMTC_MASK_SETUP     32'h3F3F3F3F
`define SMTC_MASK_PULSE     32'h7F7F7F7F
`define SMTC_MASK_CYCLE     32'h01FF01FF
`define SMTC_MASK_MODE      32'h311F3133
// Field LSBs inside each register
`define SMTC_WR_ST_LSB      0
`define SMTC_WR_CS_LSB      8
`define SMTC_RD_ST_LSB      16
`define SMTC_RD_CS_LSB      24
`define SMTC_WR_CYC_LSB     0
`define SMTC_RD_CYC_LSB     16
`define SMTC_READ_MODE_BIT  0
`define SMTC_WRITE_MODE_BIT 1
`define SMTC_WAIT_LSB       4
`define SMTC_BAT_BIT        8
`define SMTC_DBW_LSB        12
`define SMTC_FLOAT_LSB      16
`define SMTC_FLOAT_OPT_BIT  20
`define SMTC_PAGE_EN_BIT    24
`define SMTC_PAGE_SIZE_LSB  28
// Wait handling and bus width codes
`define SMTC_WAIT_FROZEN    2'h2
`define SMTC_WAIT_READY     2'h3
`define SMTC_DBW_8          2'h0
`define SMTC_DBW_16         2'h1
`endif

// File: verilog/smtc_sync.v
/*
 Two-stage synchroniser for asynchronous level inputs.
 Assumes the input is a slow level, not a pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module smtc_sync #(
	parameter W = 1
) (
	input  wire         hclk,
	input  wire         hresetn,
	input  wire         ce,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta;

	// First stage feeds only the second; resets to the idle-high level
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta <= {W{1'b1}};
			q    <= {W{1'b1}};
		end else if (ce) begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire

// File: verilog/smtc_regs.v
/*
 Register bank: four programmed words per chip select plus an active
 copy that the waveform logic uses.
 Assumes the caller masks unused bits before writing.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smtc_consts.vh"
module smtc_regs #(
	parameter CHIP_SELECT_N = 8
) (
	input  wire               hclk,
	input  wire               hresetn,
	input  wire               ce,
	input  wire               wr_en,
	input  wire [4:0]         wr_idx,
	input  wire [31:0]        wr_data,
	input  wire [4:0]         rd_idx,
	output wire [31:0]        rd_data,
	output wire [CHIP_SELECT_N*128-1:0] act_flat
);
	reg [31:0] prog [0:4*CHIP_SELECT_N-1];
	reg [31:0] act  [0:4*CHIP_SELECT_N-1];
	integer    i;

	function [31:0] rst_val;
		input [1:0] k;
		case (k)
		`SMTC_OFS_SETUP: rst_val = `SMTC_RST_SETUP;
		`SMTC_OFS_PULSE: rst_val = `SMTC_RST_PULSE;
		`SMTC_OFS_CYCLE: rst_val = `SMTC_RST_CYCLE;
		default:         rst_val = `SMTC_RST_MODE;
		endcase
	endfunction

	// Timing takes effect only on a mode write, which commits the programmed words of every chip select at once
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (i = 0; i < 4*CHIP_SELECT_N; i = i + 1) begin
				prog[i] <= rst_val(i[1:0]);
				act[i]  <= rst_val(i[1:0]);
			end
		end else if (ce && wr_en) begin
			prog[wr_idx] <= wr_data;
			if (wr_idx[1:0] == `SMTC_OFS_MODE) begin
				for (i = 0; i < 4*CHIP_SELECT_N; i = i + 1)
					act[i] <= (i[4:0] == wr_idx) ? wr_data : prog[i];
			end
		end
	end

	assign rd_data = prog[rd_idx];

	genvar g;
	generate
		for (g = 0; g < 4*CHIP_SELECT_N; g = g + 1) begin : flat
			assign act_flat[g*32 +: 32] = act[g];
		end
	endgenerate
endmodule
`default_nettype wire

// File: verilog/smtc_top.v
/*
 Static memory timing block: AHB-Lite register slave, per chip-select
 configuration and the strobe waveform engine for one access at a time.
 Assumes a single-word AHB-Lite master, a same-clock access requester
 and an external wait input that is asynchronous to hclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smtc_consts.vh"
module smtc_top #(
	parameter CHIP_SELECT_N = 8
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        ce,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        acc_req,
	input  wire        acc_write,
	input  wire [2:0]  acc_cs,
	input  wire [25:0] acc_addr,
	input  wire [3:0]  acc_be,
	output reg         acc_ready,
	output reg         acc_done,
	output reg  [25:0] mem_addr,
	output reg  [CHIP_SELECT_N-1:0] chip_select_n,
	output reg         read_strobe_n,
	output reg         write_strobe_n,
	output reg  [3:0]  byte_write_strobe_n,
	output reg  [3:0]  byte_select_n,
	input  wire        external_wait_n
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_GAP  = 3'b010;
	localparam [2:0] ST_RUN  = 3'b100;

	reg  [2:0]         state, next_state;
	reg                a_valid, a_write, a_map;
	reg  [4:0]         a_idx;
	reg  [31:0]        rd_word;
	wire [31:0]        reg_rd, wr_masked;
	wire [CHIP_SELECT_N*128-1:0] act_flat;
	wire               wait_ok, wr_en, addr_ph;

	// Access parameters latched at request time; lengths are in cycles
	reg                cur_write, wide, byte_access_type, topt;
	reg  [2:0]         cur_cs;
	reg  [3:0]         cur_be, lane, tdf;
	reg  [1:0]         wmode;
	reg  [9:0]         s_cs, p_cs, s_st, p_st, len, ctrl_s, ctrl_p, cnt;

	// Float and page tracking
	reg  [4:0]         float_cnt;
	reg  [2:0]         float_cs, page_cs;
	reg                float_opt, page_ok;
	reg  [25:0]        page_addr;

	wire [127:0]       cfg;
	wire [31:0]        c_setup, c_pulse, c_cycle, c_mode;
	wire [25:0]        pmask;
	wire [9:0]         pg_len, ctrl_end, next_cnt;
	wire               pm_read, first_pg, c_on, hold, last, done;
	wire               go, start, act_next, cs_on, st_on, float_load;

	function [9:0] setup_len;
		input [5:0] f;
		setup_len = {2'b00, f[5], 2'b00, f[4:0]};
	endfunction
	function [9:0] pulse_len;
		input [6:0] f;
		pulse_len = {1'b0, f[6], 2'b00, f[5:0]};
	endfunction
	function [9:0] cycle_len;
		input [8:0] f;
		cycle_len = {f[8:7], 1'b0, f[6:0]};
	endfunction

	function in_win;
		input [9:0] c;
		input [9:0] s;
		input [9:0] p;
		in_win = (c >= s) && (c < s + p);
	endfunction

	function [31:0] reg_mask;
		input [1:0] k;
		case (k)
		`SMTC_OFS_SETUP: reg_mask = `SMTC_MASK_SETUP;
		`SMTC_OFS_PULSE: reg_mask = `SMTC_MASK_PULSE;
		`SMTC_OFS_CYCLE: reg_mask = `SMTC_MASK_CYCLE;
		default:         reg_mask = `SMTC_MASK_MODE;
		endcase
	endfunction

	smtc_regs #(
		.CHIP_SELECT_N(CHIP_SELECT_N)
	) u_regs (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.wr_en   (wr_en),
		.wr_idx  (a_idx),
		.wr_data (wr_masked),
		.rd_idx  (haddr[6:2]),
		.rd_data (reg_rd),
		.act_flat(act_flat)
	);

	smtc_sync #(
		.W(1)
	) u_wait_sync (
		.hclk   (hclk),
		.hresetn(hresetn),
		.ce     (ce),
		.d      (external_wait_n),
		.q      (wait_ok)
	);

	// Address decode: group index from bits 6:4, word from bits 3:2
	assign addr_ph   = hsel && hready && htrans[1];
	assign wr_en     = a_valid && a_write && a_map;
	assign wr_masked = hwdata & reg_mask(a_idx[1:0]);

	// Read path, with bypass of a write still in its data phase
	always @* begin
		if (haddr[31:7] == 25'h0000000) begin
			if (wr_en && a_idx == haddr[6:2])
				rd_word = wr_masked;
			else
				rd_word = reg_rd;
		end else if (haddr[31:0] == {24'h000000, `SMTC_STATUS_ADDR}) begin
			rd_word = {16'h0000, float_cs, float_cnt, page_ok, wait_ok, 3'b000, state};
		end else begin
			rd_word = 32'h00000000;
		end
	end

	// Bus slave: zero wait states, always OKAY
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_valid   <= 1'b0;
			a_write   <= 1'b0;
			a_idx     <= 5'h00;
			a_map     <= 1'b0;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (ce) begin
			a_valid <= addr_ph;
			if (addr_ph) begin
				a_write <= hwrite;
				a_idx   <= haddr[6:2];
				a_map   <= (haddr[31:7] == 25'h0000000);
				hrdata  <= hwrite ? 32'h00000000 : rd_word;
			end
		end
	end

	// Active configuration of the requested chip select
	assign cfg     = act_flat[{acc_cs, 7'h00} +: 128];
	assign c_setup = cfg[31:0];
	assign c_pulse = cfg[63:32];
	assign c_cycle = cfg[95:64];
	assign c_mode  = cfg[127:96];

	// Page mask keeps the address bits above the selected page size
	assign pmask = ~((26'h0000004 << c_mode[`SMTC_PAGE_SIZE_LSB +: 2]) - 26'h0000001);
	assign pm_read  = c_mode[`SMTC_PAGE_EN_BIT] && !acc_write;
	assign first_pg = !(page_ok && page_cs == acc_cs && page_addr == (acc_addr & pmask));
	assign pg_len   = first_pg ? pulse_len(c_pulse[`SMTC_RD_CS_LSB +: 7])
	                           : pulse_len(c_pulse[`SMTC_RD_ST_LSB +: 7]);

	// Controlling-signal window and wait handling
	assign ctrl_end = ctrl_s + ctrl_p;
	assign c_on = in_win(cnt, ctrl_s, ctrl_p);
	assign hold = c_on && !wait_ok &&
	              ((wmode == `SMTC_WAIT_FROZEN) ||
	               (wmode == `SMTC_WAIT_READY && cnt + 10'h001 == ctrl_end));
	assign last = (cnt + 10'h001 >= len);
	assign done = state[2] && !hold && last;

	// Float gate: other chip selects wait, or overlap with setup when optimised
	assign go = (float_cnt == 5'h00) || (float_cs == cur_cs) ||
	            (float_opt && {5'h00, float_cnt} <= ctrl_s);
	assign start      = state[1] && go;
	assign act_next   = start || (state[2] && !done);
	assign next_cnt   = (state[2] && !done) ? (hold ? cnt : cnt + 10'h001) : 10'h000;
	assign cs_on      = act_next && in_win(next_cnt, s_cs, p_cs);
	assign st_on      = act_next && in_win(next_cnt, s_st, p_st);
	assign float_load = state[2] && !cur_write && !hold && (cnt + 10'h001 == ctrl_end);

	// State sequencing
	always @* begin
		case (state)
		ST_IDLE: next_state = acc_req ? ST_GAP : ST_IDLE;
		ST_GAP:  next_state = go ? ST_RUN : ST_GAP;
		ST_RUN:  next_state = done ? ST_IDLE : ST_RUN;
		default: next_state = ST_IDLE;
		endcase
	end

	// Latch one access; lengths decoded here so the engine only compares
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state     <= ST_IDLE;
			cur_write <= 1'b0;
			cur_cs    <= 3'h0;
			cur_be    <= 4'h0;
			s_cs      <= 10'h000;
			p_cs      <= 10'h000;
			s_st      <= 10'h000;
			p_st      <= 10'h000;
			len       <= 10'h000;
			ctrl_s    <= 10'h000;
			ctrl_p    <= 10'h000;
			wmode     <= 2'h0;
			wide      <= 1'b0;
			byte_access_type       <= 1'b0;
			lane      <= 4'h0;
			tdf       <= 4'h0;
			topt      <= 1'b0;
			mem_addr  <= 26'h0000000;
		end else if (ce) begin
			state <= next_state;
			if (state[0] && acc_req) begin
				cur_write <= acc_write;
				cur_cs    <= acc_cs;
				cur_be    <= acc_be;
				mem_addr  <= acc_addr;
				wmode     <= c_mode[`SMTC_WAIT_LSB +: 2];
				tdf       <= c_mode[`SMTC_FLOAT_LSB +: 4];
				topt      <= c_mode[`SMTC_FLOAT_OPT_BIT];
				byte_access_type       <= c_mode[`SMTC_BAT_BIT];
				// Byte lanes follow the bus width; code 11 treated as 32 bits
				case (c_mode[`SMTC_DBW_LSB +: 2])
				`SMTC_DBW_8:  lane <= 4'h1;
				`SMTC_DBW_16: lane <= 4'h3;
				default:      lane <= 4'hF;
				endcase
				wide <= (c_mode[`SMTC_DBW_LSB +: 2] != `SMTC_DBW_8);
				if (pm_read) begin
					// Strobes held for the whole page access, no setup or hold
					s_cs   <= 10'h000;
					s_st   <= 10'h000;
					p_cs   <= pg_len;
					p_st   <= pg_len;
					len    <= pg_len;
					ctrl_s <= 10'h000;
					ctrl_p <= pg_len;
				end else if (acc_write) begin
					s_cs <= setup_len(c_setup[`SMTC_WR_CS_LSB +: 6]);
					s_st <= setup_len(c_setup[`SMTC_WR_ST_LSB +: 6]);
					p_cs <= pulse_len(c_pulse[`SMTC_WR_CS_LSB +: 7]);
					p_st <= pulse_len(c_pulse[`SMTC_WR_ST_LSB +: 7]);
					len  <= cycle_len(c_cycle[`SMTC_WR_CYC_LSB +: 9]);
					if (c_mode[`SMTC_WRITE_MODE_BIT]) begin
						ctrl_s <= setup_len(c_setup[`SMTC_WR_ST_LSB +: 6]);
						ctrl_p <= pulse_len(c_pulse[`SMTC_WR_ST_LSB +: 7]);
					end else begin
						ctrl_s <= setup_len(c_setup[`SMTC_WR_CS_LSB +: 6]);
						ctrl_p <= pulse_len(c_pulse[`SMTC_WR_CS_LSB +: 7]);
					end
				end else begin
					s_cs <= setup_len(c_setup[`SMTC_RD_CS_LSB +: 6]);
					s_st <= setup_len(c_setup[`SMTC_RD_ST_LSB +: 6]);
					p_cs <= pulse_len(c_pulse[`SMTC_RD_CS_LSB +: 7]);
					p_st <= pulse_len(c_pulse[`SMTC_RD_ST_LSB +: 7]);
					len  <= cycle_len(c_cycle[`SMTC_RD_CYC_LSB +: 9]);
					if (c_mode[`SMTC_READ_MODE_BIT]) begin
						ctrl_s <= setup_len(c_setup[`SMTC_RD_ST_LSB +: 6]);
						ctrl_p <= pulse_len(c_pulse[`SMTC_RD_ST_LSB +: 7]);
					end else begin
						ctrl_s <= setup_len(c_setup[`SMTC_RD_CS_LSB +: 6]);
						ctrl_p <= pulse_len(c_pulse[`SMTC_RD_CS_LSB +: 7]);
					end
				end
			end
		end
	end

	// Cycle counter; frozen or stretched accesses hold it in place
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cnt <= 10'h000;
		else if (ce)
			cnt <= next_cnt;
	end

	// Bus turnaround: float count plus one, armed at the control release
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			float_cnt <= 5'h00;
			float_cs  <= 3'h0;
			float_opt <= 1'b0;
		end else if (ce) begin
			if (float_load) begin
				float_cnt <= {1'b0, tdf} + 5'h01;
				float_cs  <= cur_cs;
				float_opt <= topt;
			end else if (float_cnt != 5'h00) begin
				float_cnt <= float_cnt - 5'h01;
			end
		end
	end

	// Page tracking; any other access breaks the page
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			page_ok   <= 1'b0;
			page_cs   <= 3'h0;
			page_addr <= 26'h0000000;
		end else if (ce && state[0] && acc_req) begin
			page_ok   <= pm_read;
			page_cs   <= acc_cs;
			page_addr <= acc_addr & pmask;
		end
	end

	// Pin drivers, all registered; byte scheme only matters on wide buses
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chip_select_n       <= {CHIP_SELECT_N{1'b1}};
			read_strobe_n       <= 1'b1;
			write_strobe_n      <= 1'b1;
			byte_write_strobe_n <= 4'hF;
			byte_select_n       <= 4'hF;
			acc_ready           <= 1'b1;
			acc_done            <= 1'b0;
		end else if (ce) begin
			chip_select_n  <= ~({{(CHIP_SELECT_N-1){1'b0}}, cs_on} << cur_cs);
			read_strobe_n  <= ~(st_on && !cur_write);
			write_strobe_n <= ~(st_on && cur_write && !(wide && byte_access_type));
			byte_write_strobe_n <= ~({4{st_on && cur_write && wide && byte_access_type}} & cur_be & lane);
			byte_select_n <= ~({4{cs_on && wide && !byte_access_type}} & cur_be & lane);
			acc_ready <= (next_state == ST_IDLE);
			acc_done  <= done;
		end
	end
endmodule
`default_nettype wire

// File: bench/smtc_monitor.sv
/*
 Port checker for smtc_top: bus answer, access handshake and pin windows.
 Assumes it is bound to smtc_top and shares its hclk and hresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module smtc_monitor #(
	parameter CHIP_SELECT_N = 8
) (
	input wire logic           hclk,
	input wire logic           hresetn,
	input wire logic           hreadyout,
	input wire logic           hresp,
	input wire logic           acc_req,
	input wire logic           acc_ready,
	input wire logic           acc_done,
	input wire logic [CHIP_SELECT_N-1:0] chip_select_n,
	input wire logic           read_strobe_n,
	input wire logic           write_strobe_n,
	input wire logic [3:0]     byte_write_strobe_n,
	input wire logic [3:0]     byte_select_n
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// A request is taken, then one quiet gap cycle follows
	sequence s_take;
		acc_ready && acc_req;
	endsequence
	sequence s_gap;
		!acc_ready && !acc_done && (&chip_select_n);
	endsequence

	a_gap_after_take: assert property (s_take |=> s_gap)
		else $error("no gap cycle after a taken request");
	a_busy_two_cycles: assert property (s_take |=> !acc_ready [*2])
		else $error("access ended too early");
	a_done_one_pulse: assert property (acc_done |=> !acc_done)
		else $error("done longer than one cycle");
	a_done_with_ready: assert property (acc_done |-> acc_ready)
		else $error("done without ready");
	a_idle_pins_high: assert property (acc_ready |-> (&chip_select_n) && read_strobe_n && write_strobe_n)
		else $error("pins active while idle");
	a_one_select_low: assert property ($onehot0(~chip_select_n))
		else $error("two chip selects low");
	a_no_rw_overlap: assert property (!(!read_strobe_n && !write_strobe_n))
		else $error("read and write strobes both low");
	a_byte_lines_busy: assert property ((byte_write_strobe_n != 4'hF || byte_select_n != 4'hF) |-> !acc_ready)
		else $error("byte lines active while idle");
	a_bus_always_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not OKAY");
endmodule
bind smtc_top smtc_monitor #(.CHIP_SELECT_N(CHIP_SELECT_N)) u_mon (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .acc_req(acc_req), .acc_ready(acc_ready),
	.acc_done(acc_done), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
	.write_strobe_n(write_strobe_n), .byte_write_strobe_n(byte_write_strobe_n),
	.byte_select_n(byte_select_n));
`default_nettype wire

// File: bench/smtc_mem_model.sv
/*
 External memory stand-in that stretches accesses through its wait line.
 Assumes wait_len stays below the controlling strobe pulse length.
*/
`timescale 1ns/1ps
`default_nettype none
module smtc_mem_model (
	input wire logic       hclk,
	input wire logic       read_strobe_n,
	input wire logic       write_strobe_n,
	input wire logic [3:0] wait_len,
	output logic           external_wait_n
);
	logic [3:0] left = 4'h0;
	logic       rd_q = 1'b1;
	logic       wr_q = 1'b1;
	// Busy for wait_len cycles from each strobe fall, inside the pulse
	always @(posedge hclk) begin
		rd_q <= read_strobe_n;
		wr_q <= write_strobe_n;
		if ((rd_q && !read_strobe_n) || (wr_q && !write_strobe_n))
			left <= wait_len;
		else if (left != 4'h0)
			left <= left - 4'h1;
	end
	// Pulled up whenever the device is not holding it
	assign external_wait_n = (left == 4'h0);
endmodule
`default_nettype wire

// File: bench/test_static_memory_timing_config.sv
/*
 Self-checking bench for smtc_top: registers over AHB-Lite, measured waveforms.
 Assumes smtc_mem_model on the wait line and the bound smtc_monitor.
*/
`timescale 1ns/1ps
`default_nettype none
module test_static_memory_timing_config;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic        acc_req = 1'b0;
	logic        acc_write = 1'b0;
	logic [2:0]  acc_cs = 3'h0;
	logic [25:0] acc_addr = 26'h0;
	logic [3:0]  acc_be = 4'hF;
	logic [3:0]  wait_len = 4'h0;
	logic [31:0] hrdata, q;
	logic        hreadyout, hresp, acc_ready, acc_done, rd_n, wr_n, wait_n;
	logic [25:0] mem_addr;
	logic [7:0]  cs_n;
	logic [3:0]  bws_n, bs_n, r_bws, r_bs;
	int          fail_count = 0, total_checks = 0, r_tot, r_csl, r_stl, r_st0;

	// Master clock, 100 ns period
	initial forever #50 hclk = ~hclk;

	smtc_top #(.CHIP_SELECT_N(8)) u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.acc_req(acc_req), .acc_write(acc_write), .acc_cs(acc_cs), .acc_addr(acc_addr),
		.acc_be(acc_be), .acc_ready(acc_ready), .acc_done(acc_done), .mem_addr(mem_addr),
		.chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
		.byte_write_strobe_n(bws_n), .byte_select_n(bs_n), .external_wait_n(wait_n));
	smtc_mem_model u_mem (.hclk(hclk), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
		.wait_len(wait_len), .external_wait_n(wait_n));

	task conclude;
		if (fail_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task tmo;
		fail_count++;
		conclude();
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One bus edge with hready high; bounded so a stuck slave ends the run
	task hwait;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) tmo();
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hwait();
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		q = hrdata;
	endtask
	// One access; pins are sampled at each edge, so totals run cycle + 2
	task acc(input logic w, input logic [2:0] cs, input logic [25:0] a);
		logic s;
		@(posedge hclk);
		acc_req <= 1'b1;
		acc_write <= w;
		acc_cs <= cs;
		acc_addr <= a;
		r_tot = 0;
		do begin
			@(posedge hclk);
			r_tot++;
		end while (acc_ready !== 1'b1 && r_tot < 50);
		if (acc_ready !== 1'b1) tmo();
		acc_req <= 1'b0;
		{r_tot, r_csl, r_stl, r_st0, r_bws, r_bs} = {32'd0, 32'd0, 32'd0, 32'd0, 8'hFF};
		do begin
			@(posedge hclk);
			r_tot++;
			s = w ? (wr_n & (&bws_n)) : rd_n; // Byte write strobes stand in for the write strobe
			if (cs_n[cs] === 1'b0) r_csl++;
			if (s === 1'b0) r_stl++;
			if (s === 1'b0 && r_st0 == 0) r_st0 = r_tot;
			r_bws = r_bws & bws_n;
			r_bs = r_bs & bs_n;
		end while (acc_done !== 1'b1 && r_tot < 2000);
		if (acc_done !== 1'b1) tmo();
	endtask
	task cfg(input logic [2:0] cs, input logic [31:0] su, pu, cy, md);
		bus(1'b1, {cs, 4'h0}, su);
		bus(1'b1, {cs, 4'h4}, pu);
		bus(1'b1, {cs, 4'h8}, cy);
		bus(1'b1, {cs, 4'hC}, md);
	endtask

	// Reset values, masking of unused bits, a hole in the map
	task t_regs;
		logic [31:0] rv[4] = '{32'h0, 32'h01010101, 32'h00010001, 32'h10001000};
		logic [31:0] mk[4] = '{32'h3F3F3F3F, 32'h7F7F7F7F, 32'h01FF01FF, 32'h311F3133};
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, 32'h70 + 4 * i, 32'h0);
			chk(q, rv[i]);
			bus(1'b1, 32'h50 + 4 * i, 32'hFFFFFFFF);
			bus(1'b0, 32'h50 + 4 * i, 32'h0);
			chk(q, mk[i]);
		end
		bus(1'b1, 32'hA0, 32'hFFFFFFFF);
		bus(1'b0, 32'hA0, 32'h0);
		chk(q, 32'h0);
	endtask
	// Timing edits stay inactive until a mode register is written
	task t_commit;
		acc(1'b0, 3'h1, 26'h0);
		chk(r_tot, 3);
		bus(1'b1, 32'h18, 32'h00060001);
		acc(1'b0, 3'h1, 26'h0);
		chk(r_tot, 3);
		bus(1'b1, 32'h1C, 32'h10001000);
		acc(1'b0, 3'h1, 26'h0);
		chk(r_tot, 8);
	endtask
	// High bits of setup, pulse and cycle carry 128, 256 and 256 plus 512 weights
	task t_timing;
		cfg(3'h3, 32'h00210000, 32'h41410101, 32'h01810001, 32'h00000001);
		acc(1'b0, 3'h3, 26'h0);
		chk(r_st0, 131);
		chk(r_stl, 257);
		chk(r_csl, 257);
		chk(r_tot, 771);
	endtask
	// Chip-select controlled writes across bus widths and byte schemes
	task t_lanes;
		logic [31:0] md[4] = '{32'h1100, 32'h2000, 32'h0000, 32'h3100};
		logic [7:0] ex[4] = '{8'hCF, 8'hF0, 8'hFF, 8'h0F};
		for (int i = 0; i < 4; i++) begin
			cfg(3'h4, 32'h00000201, 32'h01010301, 32'h00010006, md[i]);
			acc(1'b1, 3'h4, 26'h0);
			chk(r_st0, 3);
			chk(r_stl, 1);
			chk(r_csl, 3);
			chk(r_tot, 8);
			chk({r_bws, r_bs}, ex[i]);
		end
	endtask
	// Each wait code against a device that holds the line low 5 cycles
	task t_wait;
		wait_len = 4'h5;
		for (int c = 0; c < 4; c++) begin
			cfg(3'h2, 32'h00010000, 32'h08060101, 32'h000C0001, 32'h1 | (c << 4));
			acc(1'b0, 3'h2, 26'h0);
			if (c < 2)
				chk(r_tot, 14);
			else
				chk(r_tot, (c == 2) ? 19 : 17);
		end
		wait_len = 4'h0;
	endtask
	// Page reads: first access long, same page short, 4-byte page break
	task t_page;
		logic [25:0] pa[3] = '{26'h0, 26'h1, 26'h4};
		int pe[3] = '{5, 2, 5};
		cfg(3'h6, 32'h0, 32'h05020101, 32'h00010001, 32'h01000001);
		for (int i = 0; i < 3; i++) begin
			acc(1'b0, 3'h6, pa[i]);
			chk(r_stl, pe[i]);
			chk(mem_addr, pa[i]);
		end
	endtask

	// Float of 15 on a read, then a write on another chip select with setup 2
	task t_float;
		for (int o = 0; o < 2; o++) begin
			cfg(3'h5, 32'h0, 32'h01010101, 32'h00010001, 32'h000F0001 | (o << 20));
			acc(1'b0, 3'h5, 26'h0);
			acc(1'b1, 3'h4, 26'h0);
			chk(r_tot, (o == 1) ? 19 : 21);
		end
	endtask

	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_commit();
		t_timing();
		t_lanes();
		t_wait();
		t_page();
		t_float();
		conclude();
	end
endmodule
`default_nettype wire
